/* File: core/sep_pkg.sv */
package sep_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned TWC_MS  = 5;
  // Longest time: exact product, 5 ms at 100 MHz gives 500000 cycles
  localparam int unsigned TWC_CYC = TWC_MS * 1000 * CLK_MHZ;
  localparam int unsigned TMR_W   = 20;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W     = 14;
  localparam int unsigned PAGE_W     = 6;
  localparam int unsigned DEPTH      = 16384;
  localparam int unsigned PAGE_BYTES = 64;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ      = 8'h03;
  localparam logic [7:0] OP_WRITE     = 8'h02;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_RD_STAT   = 8'h05;
  localparam logic [7:0] OP_WR_STAT   = 8'h01;

  // ----------------------------------------------------------------
  // Status byte layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned SB_HW_PROT = 7;
  localparam int unsigned SB_PROT_HI = 3;
  localparam int unsigned SB_PROT_LO = 2;
  localparam int unsigned SB_LATCH   = 1;
  localparam int unsigned SB_BUSY    = 0;
  localparam logic [2:0]  NV_RST     = 3'h0;
  localparam logic        LATCH_RST  = 1'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_OPC, S_ADDR, S_RDATA, S_WDATA,
    S_STRD, S_STWR, S_CMD, S_IGN
  } sep_state_e;

  typedef struct packed {
    logic cs_b;
    logic sck;
    logic si;
    logic hold_b;
  } sep_pins_s;

endpackage

/* File: core/sep_eeprom.sv */
// Operation
// [R1] First eight bits after select form the opcode, decoded before more bits.
// [R2] Serial input is taken on each rising serial clock edge.
// [R3] Host holds select low and hold high through a whole command.
// [R4] Opcode, address and data travel most significant bit first.
// [R5] The first rising clock edge after select falls takes opcode bit 7.
// [R6] Hold low freezes the command position; release resumes there.
// [R7] Read is opcode plus 16-bit address, top two bits ignored.
// [R8] Read pointer advances after each output byte while clocks continue.
// [R9] Read pointer wraps from the top address to zero.
// [R10] Raising select ends a read and stops the output.
// [R11] Latch sets only when select rises right after the full enable opcode.
// [R12] Write is opcode, 16-bit address, then one to 64 bytes in a page.
// [R13] Write data past page end wraps to that page's start.
// [R14] Write commits only if select rises on a byte boundary.
// [R15] Status read works during an internal write cycle.
// [R16] Array reads are refused during an internal write cycle.
// [R17] Internal write cycle end clears the write latch.
// [R18] Read and write opcodes decode as their fixed patterns.
// [R19] Latch set and clear opcodes decode as their fixed patterns.
// [R20] No internal write starts unless the write latch is set.
// [R21] Latch clears at reset, clear command, array or status write.
// [R22] Write-in-progress flag is one exactly while a write cycle runs.
// [R23] Output bit changes after each falling serial clock edge.
// [R24] Output floats whenever select is high.
// [R25] Internal write cycle lasts at most five milliseconds.
// [R26] Unknown opcodes are ignored with output floating until reselected.
`timescale 1ns/1ps
`default_nettype none

module sep_eeprom #(
  parameter int unsigned WC_CYCLES = sep_pkg::TWC_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Serial pins
  input  wire sep_pkg::sep_pins_s pins,
  output logic                   so,
  output logic                   so_oe,
  // Status
  output logic                   write_latch_flag,
  output logic                   write_in_progress_flag,
  output logic                   hw_protect_enable_bit,
  output logic                   block_protect_hi,
  output logic                   block_protect_lo
);
  import sep_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sep_pins_s         p1;
    sep_pins_s         p2;
    logic              sck3;
    logic              cs3;
    sep_state_e        st;
    logic [4:0]        cnt;
    logic [15:0]       sh;
    logic [7:0]        op;
    logic              rd;
    logic [ADDR_W-1:0] ptr;
    logic [63:0]       mask;
    logic              anyb;
    logic              latch;
    logic              busy;
    logic              wstat;
    logic [TMR_W-1:0]  tmr;
    logic [2:0]        pend;
    logic [2:0]        nv;
    logic              so;
    logic              so_oe;
  } sep_core_s;

  localparam logic [TMR_W-1:0] WC_LAST = TMR_W'(WC_CYCLES - 1);

  sep_core_s s_r;
  sep_core_s s_nxt;

  logic [7:0]        mem  [DEPTH];
  logic [7:0]        pbuf [PAGE_BYTES];
  logic              pb_we;
  logic [PAGE_W-1:0] pb_idx;
  logic [7:0]        pb_dat;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_a;

  logic              sel;
  logic              act;
  logic              rise;
  logic              fall;
  logic              cs_fall;
  logic              cs_rise;
  logic [15:0]       bits;
  logic [7:0]        stat_byte;
  logic [7:0]        rd_byte;

  // ----------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------
  function automatic sep_state_e decode(input logic [7:0] op,
                                        input logic       busy,
                                        input logic       latch);
    if (busy && op != OP_RD_STAT) begin
      return S_IGN; // R16
    end
    unique case (op)
      OP_READ:      return S_ADDR; // R18
      OP_WRITE:     return latch ? S_ADDR : S_IGN; // R11 R20
      OP_RD_STAT:   return S_STRD; // R15
      OP_WR_STAT:   return S_STWR;
      OP_SET_LATCH: return S_CMD; // R19
      OP_CLR_LATCH: return S_CMD; // R19
      default:      return S_IGN; // R26
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt     = s_r;
    s_nxt.p1  = pins;
    s_nxt.p2  = s_r.p1;
    s_nxt.sck3 = s_r.p2.sck;
    s_nxt.cs3 = s_r.p2.cs_b;
    sel       = !s_r.p2.cs_b && !s_r.cs3;
    act       = sel && s_r.p2.hold_b; // R6
    rise      = act && s_r.p2.sck && !s_r.sck3; // R2
    fall      = act && !s_r.p2.sck && s_r.sck3;
    cs_fall   = !s_r.p2.cs_b && s_r.cs3;
    cs_rise   = s_r.p2.cs_b && !s_r.cs3;
    bits      = {s_r.sh[14:0], s_r.p2.si}; // R4
    stat_byte = {s_r.nv[2], 3'h0, s_r.nv[1:0], s_r.latch, s_r.busy}; // R22
    rd_byte   = (s_r.st == S_RDATA) ? mem[s_r.ptr] : stat_byte;
    pb_we     = 1'b0;
    pb_idx    = s_r.ptr[PAGE_W-1:0];
    pb_dat    = bits[7:0];
    mem_we    = s_r.busy && !s_r.wstat && (s_r.tmr < TMR_W'(PAGE_BYTES))
                && s_r.mask[s_r.tmr[PAGE_W-1:0]];
    mem_a     = {s_r.ptr[ADDR_W-1:PAGE_W], s_r.tmr[PAGE_W-1:0]};

    if (cs_fall) begin
      s_nxt.st  = S_OPC; // R5
      s_nxt.cnt = 5'h0;
    end else if (cs_rise) begin
      if (s_r.st == S_CMD && s_r.op == OP_SET_LATCH && !s_r.busy) begin
        s_nxt.latch = 1'b1; // R11
      end
      if (s_r.st == S_CMD && s_r.op == OP_CLR_LATCH) begin
        s_nxt.latch = 1'b0; // R21
      end
      if (s_r.st == S_WDATA && s_r.cnt == 5'h0 && s_r.anyb && s_r.latch)
      begin
        s_nxt.busy  = 1'b1; // R14 R20
        s_nxt.wstat = 1'b0;
        s_nxt.tmr   = '0;
      end
      if (s_r.st == S_CMD && s_r.op == OP_WR_STAT && s_r.latch) begin
        s_nxt.busy  = 1'b1; // R20
        s_nxt.wstat = 1'b1;
        s_nxt.tmr   = '0;
      end
      s_nxt.st = S_IDLE; // R10
    end else if (rise) begin
      unique case (s_r.st)
        S_OPC: begin
          s_nxt.sh  = bits;
          s_nxt.cnt = s_r.cnt + 5'h1;
          if (s_r.cnt == 5'h7) begin
            s_nxt.op  = bits[7:0]; // R1
            s_nxt.rd  = (bits[7:0] == OP_READ); // R18
            s_nxt.cnt = 5'h0;
            s_nxt.st  = decode(bits[7:0], s_r.busy, s_r.latch);
          end
        end
        S_ADDR: begin
          s_nxt.sh  = bits;
          s_nxt.cnt = s_r.cnt + 5'h1;
          if (s_r.cnt == 5'hF) begin
            s_nxt.ptr  = bits[ADDR_W-1:0]; // R7 R12
            s_nxt.cnt  = 5'h0;
            s_nxt.mask = '0;
            s_nxt.anyb = 1'b0;
            s_nxt.st   = s_r.rd ? S_RDATA : S_WDATA;
          end
        end
        S_WDATA: begin
          s_nxt.sh  = bits;
          s_nxt.cnt = s_r.cnt + 5'h1;
          if (s_r.cnt == 5'h7) begin
            pb_we      = 1'b1;
            s_nxt.mask[s_r.ptr[PAGE_W-1:0]] = 1'b1;
            s_nxt.ptr[PAGE_W-1:0] = s_r.ptr[PAGE_W-1:0] + 6'h1; // R13
            s_nxt.anyb = 1'b1;
            s_nxt.cnt  = 5'h0;
          end
        end
        S_STWR: begin
          s_nxt.sh  = bits;
          s_nxt.cnt = s_r.cnt + 5'h1;
          if (s_r.cnt == 5'h7) begin
            s_nxt.pend = {bits[SB_HW_PROT], bits[SB_PROT_HI],
                          bits[SB_PROT_LO]};
            s_nxt.st   = S_CMD;
          end
        end
        S_CMD:   s_nxt.st = S_IGN; // R11
        default: ;
      endcase
    end else if (fall && (s_r.st == S_RDATA || s_r.st == S_STRD)) begin
      s_nxt.so  = rd_byte[3'h7 - s_r.cnt[2:0]]; // R23 R4
      s_nxt.cnt = s_r.cnt + 5'h1;
      if (s_r.cnt[2:0] == 3'h7) begin
        s_nxt.cnt = 5'h0;
        if (s_r.st == S_RDATA) begin
          s_nxt.ptr = s_r.ptr + 14'h1; // R8 R9
        end
      end
    end

    // Drive only in a read phase, once the first bit is out
    s_nxt.so_oe = act && (s_r.st == S_RDATA || s_r.st == S_STRD)
                  && (s_r.so_oe || fall); // R24 R26

    if (s_r.busy) begin
      s_nxt.tmr = s_r.tmr + 20'h1;
      if (s_r.tmr == WC_LAST) begin
        s_nxt.busy  = 1'b0; // R25 R22
        s_nxt.latch = 1'b0; // R17 R21
        if (s_r.wstat) begin
          s_nxt.nv = s_r.pend;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_r           <= '0;
      s_r.p1.cs_b   <= 1'b1;
      s_r.p2.cs_b   <= 1'b1;
      s_r.cs3       <= 1'b1;
      s_r.p1.hold_b <= 1'b1;
      s_r.p2.hold_b <= 1'b1;
      s_r.latch     <= LATCH_RST; // R21
      s_r.nv        <= NV_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (pb_we) begin
      pbuf[pb_idx] <= pb_dat;
    end
    if (mem_we) begin
      mem[mem_a] <= pbuf[s_r.tmr[PAGE_W-1:0]];
    end
  end

  assign so                     = s_r.so;
  assign so_oe                  = s_r.so_oe;
  assign write_latch_flag       = s_r.latch;
  assign write_in_progress_flag = s_r.busy;
  assign hw_protect_enable_bit  = s_r.nv[2];
  assign block_protect_hi       = s_r.nv[1];
  assign block_protect_lo       = s_r.nv[0];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_opcode_capture: assert property ( // R1
    s_r.st == S_OPC && rise && s_r.cnt == 5'h7 && !cs_fall && !cs_rise
    |=> s_r.op == $past(bits[7:0]))
    else $error("opcode not captured");

  a_so_float_desel: assert property ( // R24
    s_r.p2.cs_b |=> !so_oe)
    else $error("output driven while deselected");

  a_hold_freeze: assert property ( // R6
    !s_r.p2.hold_b && sel && !s_r.busy
    |=> s_r.cnt == $past(s_r.cnt) && s_r.st == $past(s_r.st))
    else $error("position moved during hold");

  a_read_advance: assert property ( // R8
    s_r.st == S_RDATA && fall && s_r.cnt[2:0] == 3'h7
    |=> s_r.ptr == $past(s_r.ptr) + 14'h1)
    else $error("read pointer did not advance");

  a_page_wrap: assert property ( // R13
    s_r.st == S_WDATA && rise && s_r.cnt == 5'h7 && sel
    |=> s_r.ptr[13:6] == $past(s_r.ptr[13:6]))
    else $error("write left its page");

  a_commit_cause: assert property ( // R14
    $rose(s_r.busy) |-> $past(cs_rise) && $past(s_r.latch))
    else $error("write cycle without valid commit");

  a_commit_boundary: assert property ( // R14
    $rose(s_r.busy) && !s_r.wstat |-> $past(s_r.cnt == 5'h0 && s_r.anyb))
    else $error("array write started off a byte boundary");

  a_latch_set_cause: assert property ( // R11
    $rose(s_r.latch)
    |-> $past(cs_rise && s_r.st == S_CMD && s_r.op == OP_SET_LATCH))
    else $error("write latch set without enable");

  a_latch_clr_cmd: assert property ( // R21
    cs_rise && s_r.st == S_CMD && s_r.op == OP_CLR_LATCH |=> !s_r.latch)
    else $error("write latch not cleared by clear command");

  a_latch_clear_end: assert property ( // R17
    $fell(write_in_progress_flag) |-> !write_latch_flag)
    else $error("latch not cleared after write");

  a_no_read_busy: assert property ( // R16
    s_r.busy |-> s_r.st != S_RDATA)
    else $error("array read during write cycle");

  a_so_on_fall: assert property ( // R23
    $changed(so) |-> $past(fall))
    else $error("output changed off a falling edge");

  a_ignore_float: assert property ( // R26
    s_r.st == S_IGN |=> !so_oe)
    else $error("output driven after unknown opcode");

  c_read_stream: cover property (
    s_r.st == S_RDATA && fall && s_r.cnt[2:0] == 3'h7);
  c_write_commit: cover property ($rose(s_r.busy) && !s_r.wstat);
  c_status_busy: cover property (s_r.st == S_STRD && s_r.busy);
  c_hold_cmd: cover property (!s_r.p2.hold_b && sel);
  c_bad_opcode: cover property (s_r.st == S_IGN && rise);

endmodule // sep_eeprom

`default_nettype wire

/* File: test/sep_host.sv */
`timescale 1ns/1ps
`default_nettype none

module sep_host (
  // Clock
  input  wire logic              clk,
  // Serial pins
  output var sep_pkg::sep_pins_s pins,
  input  wire logic              so_w
);
  import sep_pkg::*;

  // Bus idle: deselected, clock low, not held
  task automatic idle();
    pins <= '{cs_b: 1'b1, sck: 1'b0, si: 1'b0, hold_b: 1'b1};
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic sel();
    @(posedge clk);
    pins.cs_b <= 1'b0;
    tick(4);
  endtask

  // Shifts nb bits of tx out, most significant first, sampling so_w
  task automatic xfer(input logic [7:0] tx, input int nb,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      pins.sck <= 1'b0;
      pins.si  <= tx[i];
      tick(4);
      pins.sck <= 1'b1;
      tick(4);
      rx = {rx[6:0], so_w};
    end
  endtask

  // Pause with clock and data noise while hold is low
  task automatic pause();
    pins.sck <= 1'b0;
    tick(4);
    pins.hold_b <= 1'b0;
    repeat (2) begin
      tick(4);
      pins.sck <= 1'b1;
      pins.si  <= ~pins.si;
      tick(4);
      pins.sck <= 1'b0;
    end
    tick(4);
    pins.hold_b <= 1'b1;
    tick(4);
  endtask

  task automatic desel();
    pins.sck <= 1'b0;
    tick(4);
    pins.cs_b <= 1'b1;
    pins.si   <= ~pins.si;
    tick(8);
  endtask

endmodule // sep_host

`default_nettype wire

/* File: test/spi_serial_eeprom_protocol_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module spi_serial_eeprom_protocol_tb_top;
  import sep_pkg::*;

  localparam int unsigned WC      = 1000;
  localparam int          CYC_MAX = 30000;

  logic       clk;
  logic       rst_b;
  logic       so;
  logic       so_oe;
  logic       latch_f;
  logic       busy_f;
  logic       hw_prot;
  logic       bphi;
  logic       bplo;
  sep_pins_s  pins;
  logic [7:0] rx;
  int         n_fail;
  int         samples_checked;
  int         cyc = 0;
  wire logic       so_w = so_oe ? so : 1'bz;
  wire logic [7:0] st = {3'h0, hw_prot, bphi, bplo, latch_f, busy_f};

  sep_eeprom #(.WC_CYCLES(WC)) dut (
    .clk(clk), .rst_b(rst_b), .pins(pins), .so(so), .so_oe(so_oe),
    .write_latch_flag(latch_f), .write_in_progress_flag(busy_f),
    .hw_protect_enable_bit(hw_prot), .block_protect_hi(bphi),
    .block_protect_lo(bplo));

  sep_host host (.clk(clk), .pins(pins), .so_w(so_w));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic op(input logic [7:0] c);
    host.sel();
    host.xfer(c, 8, rx);
    host.desel();
  endtask

  // n bytes from d0 upward; the last one carries nb bits
  task automatic wr(input logic [15:0] a, input logic [7:0] d0,
                    input int n, input int nb);
    host.sel();
    host.xfer(OP_WRITE, 8, rx);
    host.xfer(a[15:8], 8, rx);
    host.xfer(a[7:0], 8, rx);
    for (int k = 0; k < n; k++) begin
      host.xfer(d0 + 8'(k), (k == n - 1) ? nb : 8, rx);
    end
    host.desel();
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e [3],
                    input int n);
    host.sel();
    host.xfer(OP_READ, 8, rx);
    host.xfer(a[15:8], 8, rx);
    host.pause();
    host.xfer(a[7:0], 8, rx);
    for (int k = 0; k < n; k++) begin
      host.xfer(8'h00, 8, rx);
      chk(rx, e[k]);
    end
    host.desel();
    chk({7'h0, so_oe}, 8'h00);
  endtask

  task automatic wait_idle();
    for (int k = 0; k < WC + 20 && busy_f !== 1'b0; k++) @(posedge clk);
    chk(st & 8'h03, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  initial begin
    rst_b = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    host.idle();
    fork
      begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        chk(st, 8'h00);
        wr(16'h0000, 8'h11, 1, 8);
        chk(st, 8'h00);
        op(OP_SET_LATCH);
        chk(st, 8'h02);
        op(OP_CLR_LATCH);
        chk(st, 8'h00);
        // Enable and write in one frame must not write
        host.sel();
        host.xfer(OP_SET_LATCH, 8, rx);
        host.xfer(OP_WRITE, 8, rx);
        host.xfer(8'h00, 8, rx);
        host.xfer(8'h00, 8, rx);
        host.xfer(8'h77, 8, rx);
        host.desel();
        chk(st, 8'h00);
        op(OP_SET_LATCH);
        wr(16'h3FFE, 8'hA0, 4, 8);
        chk(st, 8'h03);
        host.sel();
        host.xfer(OP_RD_STAT, 8, rx);
        host.xfer(8'h00, 8, rx);
        host.desel();
        chk(rx, 8'h03);
        host.sel();
        host.xfer(OP_READ, 8, rx);
        host.xfer(8'h00, 8, rx);
        host.xfer(8'h00, 8, rx);
        host.xfer(8'h00, 8, rx);
        chk({7'h0, so_oe}, 8'h00);
        host.desel();
        wait_idle();
        chk(st, 8'h00);
        op(OP_SET_LATCH);
        wr(16'hC000, 8'h5A, 1, 8);
        wait_idle();
        rd(16'h7FFE, '{8'hA0, 8'hA1, 8'h5A}, 3);
        rd(16'hBFC0, '{8'hA2, 8'hA3, 8'h00}, 2);
        op(OP_SET_LATCH);
        wr(16'h0000, 8'hEE, 2, 3);
        chk(st, 8'h02);
        rd(16'h0000, '{8'h5A, 8'h00, 8'h00}, 1);
        host.sel();
        host.xfer(8'hFF, 8, rx);
        host.xfer(8'h00, 8, rx);
        chk({7'h0, so_oe}, 8'h00);
        host.desel();
        op(OP_SET_LATCH);
        host.sel();
        host.xfer(OP_WR_STAT, 8, rx);
        host.xfer(8'h8C, 8, rx);
        host.desel();
        wait_idle();
        chk(st, 8'h1C);
        op(OP_RD_STAT);
        host.sel();
        host.xfer(OP_RD_STAT, 8, rx);
        host.xfer(8'h00, 8, rx);
        host.desel();
        chk(rx, 8'h8C);
      end
      begin
        // Ceiling on run length counts as a mismatch
        wait (cyc >= CYC_MAX);
        n_fail++;
      end
    join_any
    complete_run();
  end

endmodule // spi_serial_eeprom_protocol_tb_top

`default_nettype wire
